// *** include/rtcdv_regs.svh ***
// Constants of the time-base divider and periodic rate control
`ifndef RTCDV_REGS_SVH
`define RTCDV_REGS_SVH
// ----------------------------------------------------------------
// Host ports and indices
// ----------------------------------------------------------------
`define RTCDV_INDEX_PORT     8'h70
`define RTCDV_DATA_PORT      8'h71
`define RTCDV_IDX_CTRL_A     8'h0A
`define RTCDV_IDX_CTRL_B     8'h0B
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTCDV_PEND_BIT       7
`define RTCDV_DIV_MSB        6
`define RTCDV_DIV_LSB        4
`define RTCDV_RATE_MSB       3
`define RTCDV_RATE_LSB       0
`define RTCDV_INHIBIT_BIT    7
// ----------------------------------------------------------------
// Divider codes and reset values
// ----------------------------------------------------------------
`define RTCDV_DIV_4M         3'h0
`define RTCDV_DIV_1M         3'h1
`define RTCDV_DIV_32K        3'h2
`define RTCDV_DIV_RESET      3'h2
`define RTCDV_RATE_RESET     4'h6
`define RTCDV_PRE_LIM_4M     7'h7F
`define RTCDV_PRE_LIM_1M     7'h1F
`define RTCDV_PRE_LIM_32K    7'h00
// ----------------------------------------------------------------
// Update timing, counted in 32.768 kHz base ticks
// ----------------------------------------------------------------
`define RTCDV_BASE_TICK_NS   30518
`define RTCDV_PEND_LEAD_US   244
`define RTCDV_UPD_BUSY_US    2000
`define RTCDV_PEND_LEAD_TICKS ((`RTCDV_PEND_LEAD_US * 1000 + `RTCDV_BASE_TICK_NS - 1) / `RTCDV_BASE_TICK_NS)
`define RTCDV_UPD_BUSY_TICKS ((`RTCDV_UPD_BUSY_US * 1000 + `RTCDV_BASE_TICK_NS - 1) / `RTCDV_BASE_TICK_NS)
`endif

// *** include/rtcdv_pkg.sv ***
// Types of the time-base divider and periodic rate control
package rtcdv_pkg;
   typedef enum logic [2:0] {
      UPD_IDLE = 3'b001,
      UPD_LEAD = 3'b010,
      UPD_BUSY = 3'b100
   } rtcdv_upd_state_t;
endpackage : rtcdv_pkg

// *** include/rtcdv_core_if.sv ***
// Signals between the control logic and the prescaler chain
`timescale 1ns/100ps
interface rtcdv_core_if;
   logic       oscTick;
   logic [2:0] divSelect;
   logic [3:0] rateSelect;
   logic       chainReset;
   logic       periodicEvent;
   logic       leadTick;
   logic       secondTick;
   logic       baseTick;
   modport ctrl (output oscTick, divSelect, rateSelect, chainReset,
                 input  periodicEvent, leadTick, secondTick, baseTick);
   modport chain (input  oscTick, divSelect, rateSelect, chainReset,
                  output periodicEvent, leadTick, secondTick, baseTick);
endinterface : rtcdv_core_if

// *** verilog/rtcdv_prescaler.sv ***
// Divider/prescaler chain with periodic tap and second tick
`timescale 1ns/100ps
`include "rtcdv_regs.svh"
module rtcdv_prescaler
   import rtcdv_pkg::*;
#(
   parameter int CHAIN_BITS = 15
) (
   input wire logic   clk,
   input wire logic   rst_n,
   rtcdv_core_if.chain core
);
   localparam logic [CHAIN_BITS-1:0] LEAD_AT =
      CHAIN_BITS'((1 << CHAIN_BITS) - 1 - `RTCDV_PEND_LEAD_TICKS);

   logic [6:0]            preCnt;
   logic [6:0]            next_preCnt;
   logic [CHAIN_BITS-1:0] chainCnt;
   logic [CHAIN_BITS-1:0] next_chainCnt;
   logic                  next_baseTick;
   logic                  next_periodic;
   logic                  next_lead;
   logic                  next_second;
   logic [6:0]            preLimit;
   logic                  validBase;
   logic [3:0]            tapBits;
   logic [CHAIN_BITS-1:0] tapMask;

   // ----------------------------------------------------------------
   // Tap selection
   // ----------------------------------------------------------------
   always_comb begin
      unique case (core.rateSelect)
         4'h1:    tapBits = 4'h7;
         4'h2:    tapBits = 4'h8;
         default: tapBits = core.rateSelect - 4'h1;
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < CHAIN_BITS; gi++) begin : g_tap
         assign tapMask[gi] = (gi < int'(tapBits));
      end
   endgenerate

   // ----------------------------------------------------------------
   // Chain next state
   // ----------------------------------------------------------------
   always_comb begin
      validBase = 1'b1;
      unique case (core.divSelect)
         `RTCDV_DIV_4M:  preLimit = `RTCDV_PRE_LIM_4M;
         `RTCDV_DIV_1M:  preLimit = `RTCDV_PRE_LIM_1M;
         `RTCDV_DIV_32K: preLimit = `RTCDV_PRE_LIM_32K;
         default: begin
            preLimit  = `RTCDV_PRE_LIM_32K;
            validBase = 1'b0;
         end
      endcase
      next_preCnt   = preCnt;
      next_chainCnt = chainCnt;
      next_baseTick = 1'b0;
      next_periodic = 1'b0;
      next_lead     = 1'b0;
      next_second   = 1'b0;
      if (core.chainReset) begin
         // Held at zero so the first second is full length after release
         next_preCnt   = 7'h00;
         next_chainCnt = '0;
      end else if (validBase && core.oscTick) begin
         if (preCnt >= preLimit) begin
            next_preCnt   = 7'h00;
            next_baseTick = 1'b1;
         end else begin
            next_preCnt = preCnt + 7'h01;
         end
      end
      if (core.baseTick && !core.chainReset && validBase) begin
         next_chainCnt = chainCnt + CHAIN_BITS'(1);
         next_periodic = (core.rateSelect != 4'h0)
                         && ((chainCnt & tapMask) == tapMask);
         next_lead     = (chainCnt == LEAD_AT);
         next_second   = (chainCnt == '1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         preCnt             <= 7'h00;
         chainCnt           <= '0;
         core.baseTick      <= 1'b0;
         core.periodicEvent <= 1'b0;
         core.leadTick      <= 1'b0;
         core.secondTick    <= 1'b0;
      end else begin
         preCnt             <= next_preCnt;
         chainCnt           <= next_chainCnt;
         core.baseTick      <= next_baseTick;
         core.periodicEvent <= next_periodic;
         core.leadTick      <= next_lead;
         core.secondTick    <= next_second;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_chain_reset_quiet: assert property (core.chainReset |=> ##1 !core.periodicEvent && !core.secondTick)
      else $error("event seen while chain held in reset");
   a_rate_zero_off: assert property ($past(core.rateSelect) == 4'h0 |-> !core.periodicEvent)
      else $error("periodic event with rate select zero");
   a_base_32k_tick: assert property (core.divSelect == `RTCDV_DIV_32K && core.oscTick && !core.chainReset
                                     |=> core.baseTick)
      else $error("32 kHz base did not pass every oscillator edge");
   a_fast_tap: assert property (core.rateSelect == 4'h3 && core.baseTick && !core.chainReset
                                && validBase && chainCnt[1:0] == 2'b11 |=> core.periodicEvent)
      else $error("fast periodic tap missed");
   a_periodic_from_base: assert property (core.periodicEvent |-> $past(core.baseTick))
      else $error("periodic event not derived from a prescaler step");
endmodule : rtcdv_prescaler

// *** verilog/rtcdv_rate_control.sv ***
// Time-base divider and periodic rate control with index/data access
//
// Behaviour
// - Bits 6 to 4 pick the oscillator base: 000 for 4.19430 MHz, 001 for 1.048576 MHz, 010 for 32.768 kHz.
// - Bits 3 to 0 set the periodic rate, taken from a tap of the prescaler.
// - The periodic event and the alarm event are raised independently of each other.
// - Alarm and periodic events share one interrupt request line.
// - Periodic rates faster than once per second are supported.
// - Update cycles run only with a valid base, the chain out of reset and update inhibit clear.
// - The host writes index 0AH at port 70H, then reads or writes data at port 71H.
// - Bit 7 is a read-only update-pending flag, untouched by reset and cleared by writing one to inhibit.
`timescale 1ns/100ps
`include "rtcdv_regs.svh"
module rtcdv_rate_control
   import rtcdv_pkg::*;
#(
   parameter int CHAIN_BITS = 15
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       oscillator_input,
   input  wire logic [7:0] ioAddr,
   input  wire logic       ioWr,
   input  wire logic       ioRd,
   input  wire logic [7:0] ioWrData,
   input  wire logic       alarmMatch,
   output logic [7:0]      ioRdData,
   output logic            hostIrq,
   output logic            updateStrobe
);
   localparam logic [6:0] BUSY_LAST = 7'(`RTCDV_UPD_BUSY_TICKS - 1);

   rtcdv_core_if core ();

   logic             oscSync1;
   logic             oscSync2;
   logic             oscSync3;
   logic [7:0]       indexReg;
   logic [7:0]       next_indexReg;
   logic [2:0]       divSelect;
   logic [2:0]       next_divSelect;
   logic [3:0]       rateSelect;
   logic [3:0]       next_rateSelect;
   logic             updateInhibit;
   logic             next_updateInhibit;
   logic             updatePending;
   logic             next_updatePending;
   logic [7:0]       next_ioRdData;
   logic             next_hostIrq;
   logic             next_updateStrobe;
   rtcdv_upd_state_t updState;
   rtcdv_upd_state_t next_updState;
   logic [6:0]       busyCnt;
   logic [6:0]       next_busyCnt;
   logic             wrIndex;
   logic             wrData;
   logic             inhibitWr1;
   logic             updatesAllowed;
   logic             busyDone;
   logic             validBase;

   // ----------------------------------------------------------------
   // Oscillator pin sync and edge
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oscSync1 <= 1'b0;
         oscSync2 <= 1'b0;
         oscSync3 <= 1'b0;
      end else begin
         oscSync1 <= oscillator_input;
         oscSync2 <= oscSync1;
         oscSync3 <= oscSync2;
      end
   end

   assign core.oscTick    = oscSync2 & ~oscSync3;
   assign core.divSelect  = divSelect;
   assign core.rateSelect = rateSelect;
   assign core.chainReset = (divSelect[2:1] == 2'b11);

   rtcdv_prescaler #(
      .CHAIN_BITS (CHAIN_BITS)
   ) u_prescaler (
      .clk   (clk),
      .rst_n (rst_n),
      .core  (core.chain)
   );

   // ----------------------------------------------------------------
   // Host index/data port
   // ----------------------------------------------------------------
   assign wrIndex    = ioWr && (ioAddr == `RTCDV_INDEX_PORT);
   assign wrData     = ioWr && (ioAddr == `RTCDV_DATA_PORT);
   assign inhibitWr1 = wrData && (indexReg == `RTCDV_IDX_CTRL_B) && ioWrData[`RTCDV_INHIBIT_BIT];

   always_comb begin
      next_indexReg      = wrIndex ? ioWrData : indexReg;
      next_divSelect     = divSelect;
      next_rateSelect    = rateSelect;
      next_updateInhibit = updateInhibit;
      if (wrData && indexReg == `RTCDV_IDX_CTRL_A) begin
         // Bit 7 is status only, a write there is dropped
         next_divSelect  = ioWrData[`RTCDV_DIV_MSB:`RTCDV_DIV_LSB];
         next_rateSelect = ioWrData[`RTCDV_RATE_MSB:`RTCDV_RATE_LSB];
      end
      if (wrData && indexReg == `RTCDV_IDX_CTRL_B)
         next_updateInhibit = ioWrData[`RTCDV_INHIBIT_BIT];
      next_ioRdData = ioRdData;
      if (ioRd && ioAddr == `RTCDV_INDEX_PORT)
         next_ioRdData = indexReg;
      else if (ioRd && ioAddr == `RTCDV_DATA_PORT) begin
         unique case (indexReg)
            `RTCDV_IDX_CTRL_A: next_ioRdData = {updatePending, divSelect, rateSelect};
            `RTCDV_IDX_CTRL_B: next_ioRdData = {updateInhibit, 7'h00};
            default:           next_ioRdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         indexReg      <= 8'h00;
         divSelect     <= `RTCDV_DIV_RESET;
         rateSelect    <= `RTCDV_RATE_RESET;
         updateInhibit <= 1'b0;
         ioRdData      <= 8'h00;
      end else begin
         indexReg      <= next_indexReg;
         divSelect     <= next_divSelect;
         rateSelect    <= next_rateSelect;
         updateInhibit <= next_updateInhibit;
         ioRdData      <= next_ioRdData;
      end
   end

   // ----------------------------------------------------------------
   // Update cycle sequencer
   // ----------------------------------------------------------------
   assign validBase      = (divSelect == `RTCDV_DIV_4M) || (divSelect == `RTCDV_DIV_1M)
                           || (divSelect == `RTCDV_DIV_32K);
   assign updatesAllowed = validBase && !core.chainReset && !updateInhibit;
   assign busyDone       = (updState == UPD_BUSY) && core.baseTick && (busyCnt == BUSY_LAST);

   always_comb begin
      next_updState     = updState;
      next_busyCnt      = busyCnt;
      next_updateStrobe = 1'b0;
      if (!updatesAllowed)
         next_updState = UPD_IDLE;
      else begin
         unique case (updState)
            UPD_IDLE: if (core.leadTick) next_updState = UPD_LEAD;
            UPD_LEAD: if (core.secondTick) begin
               next_updState     = UPD_BUSY;
               next_busyCnt      = 7'h00;
               next_updateStrobe = 1'b1;
            end
            UPD_BUSY: if (busyDone) next_updState = UPD_IDLE;
                      else if (core.baseTick) next_busyCnt = busyCnt + 7'h01;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         updState     <= UPD_IDLE;
         busyCnt      <= 7'h00;
         updateStrobe <= 1'b0;
      end else begin
         updState     <= next_updState;
         busyCnt      <= next_busyCnt;
         updateStrobe <= next_updateStrobe;
      end
   end

   // ----------------------------------------------------------------
   // Update-pending flag, deliberately outside reset
   // ----------------------------------------------------------------
   always_comb begin
      next_updatePending = updatePending;
      if (busyDone || inhibitWr1)
         next_updatePending = 1'b0;
      // A new lead wins over a clear in the same cycle
      if (core.leadTick && updatesAllowed && updState == UPD_IDLE)
         next_updatePending = 1'b1;
   end

   always_ff @(posedge clk) begin
      updatePending <= next_updatePending;
   end

   // ----------------------------------------------------------------
   // Shared interrupt request
   // ----------------------------------------------------------------
   assign next_hostIrq = core.periodicEvent | alarmMatch;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         hostIrq <= 1'b0;
      else
         hostIrq <= next_hostIrq;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence sWrCtrlA;
      wrData && indexReg == `RTCDV_IDX_CTRL_A;
   endsequence
   sequence sInhibitClear;
      inhibitWr1 && !core.leadTick;
   endsequence

   a_irq_shared: assert property ((core.periodicEvent || alarmMatch) |=> hostIrq)
      else $error("event did not reach the shared request line");
   a_irq_cause: assert property (!core.periodicEvent && !alarmMatch |=> !hostIrq)
      else $error("request raised without a source");
   a_alarm_alone: assert property (alarmMatch && rateSelect == 4'h0 |=> hostIrq)
      else $error("alarm blocked by periodic setting");
   a_ctrl_write: assert property (sWrCtrlA |=> rateSelect == $past(ioWrData[3:0])
                                  && divSelect == $past(ioWrData[6:4]))
      else $error("control write not stored");
   a_div_hold: assert property (divSelect[2:1] == 2'b11 |-> core.chainReset)
      else $error("chain not held with divider reset code");
   a_no_update: assert property (!updatesAllowed |=> !updateStrobe && updState == UPD_IDLE)
      else $error("update cycle ran while not allowed");
   a_pend_clear: assert property (sInhibitClear |=> !updatePending)
      else $error("inhibit write did not clear pending flag");
   a_pend_before: assert property (updateStrobe |-> updatePending)
      else $error("update started without pending flag");
endmodule : rtcdv_rate_control

// *** tb/rtcdv_host_model.sv ***
// Host processor model driving the index/data port pair
`timescale 1ns/100ps
`include "rtcdv_regs.svh"
module rtcdv_host_model (
   input  wire logic       clk,
   output logic [7:0]      ioAddr,
   output logic            ioWr,
   output logic            ioRd,
   output logic [7:0]      ioWrData,
   input  wire logic [7:0] ioRdData
);
   // ----------------------------------------
   // Port cycles, launched on the falling edge
   // ----------------------------------------
   initial begin
      ioAddr = 8'h00;
      ioWr = 1'b0;
      ioRd = 1'b0;
      ioWrData = 8'h00;
   end

   // Released lines show the inverse so a stale value cannot pass for a good one
   task automatic portWrite(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      ioAddr <= addr;
      ioWrData <= data;
      ioWr <= 1'b1;
      @(negedge clk);
      ioWr <= 1'b0;
      ioAddr <= ~addr;
      ioWrData <= ~data;
   endtask : portWrite

   task automatic portRead(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk);
      ioAddr <= addr;
      ioRd <= 1'b1;
      @(negedge clk);
      ioRd <= 1'b0;
      ioAddr <= ~addr;
      @(negedge clk);
      data = ioRdData;
   endtask : portRead

   task automatic regWrite(input logic [7:0] idx, input logic [7:0] data);
      portWrite(`RTCDV_INDEX_PORT, idx);
      portWrite(`RTCDV_DATA_PORT, data);
   endtask : regWrite

   task automatic regRead(input logic [7:0] idx, output logic [7:0] data);
      portWrite(`RTCDV_INDEX_PORT, idx);
      portRead(`RTCDV_DATA_PORT, data);
   endtask : regRead
endmodule : rtcdv_host_model

// *** tb/test_rtc_divider_rate_control.sv ***
// Self-checking bench of the divider and periodic rate control
`timescale 1ns/100ps
`include "rtcdv_regs.svh"
module test_rtc_divider_rate_control;
   localparam int OSC_HALF = 4;
   localparam int OSC_CLKS = 8;
   localparam int LIMIT    = 80000;
   // Short chain so whole update cycles fit in the run; rates above 9 need a longer one
   localparam int CHAIN    = 8;
   logic       clk;
   logic       rst_n;
   logic       oscillator_input;
   logic       alarmMatch;
   logic [7:0] ioAddr;
   logic       ioWr;
   logic       ioRd;
   logic [7:0] ioWrData;
   logic [7:0] ioRdData;
   logic       hostIrq;
   logic       updateStrobe;
   logic [7:0] rd;
   int         gap;
   int         failures = 0;
   int         compares = 0;
   int         cycles   = 0;

   rtcdv_rate_control #(.CHAIN_BITS(CHAIN)) rtcdv_rate_control_i (.clk(clk), .rst_n(rst_n),
      .oscillator_input(oscillator_input), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData),
      .alarmMatch(alarmMatch), .ioRdData(ioRdData), .hostIrq(hostIrq), .updateStrobe(updateStrobe));
   rtcdv_host_model rtcdv_host_model_i (.clk(clk), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
      .ioWrData(ioWrData), .ioRdData(ioRdData));

   // ----------------------------------------
   // Clock, oscillator and hang guard
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Oscillator kept well below clk/4 so the synchroniser sees every edge
   initial begin
      oscillator_input = 1'b0;
      forever begin
         repeat (OSC_HALF) @(negedge clk);
         oscillator_input = ~oscillator_input;
      end
   end

   initial begin
      forever begin
         @(posedge clk);
         cycles++;
         if (cycles == LIMIT) begin
            failures++;
            results();
         end
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : checkByte

   task automatic checkCount(input int got, input int exp);
      compares++;
      if (got != exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : checkCount

   task automatic setCtrl(input logic [2:0] div, input logic [3:0] rate);
      rtcdv_host_model_i.regWrite(`RTCDV_IDX_CTRL_A, {1'b0, div, rate});
   endtask : setCtrl

   // Clocks between two interrupt pulses, both waits bounded
   task automatic measureGap(output int n);
      int w;
      w = 0;
      // Let a pulse of the old setting drain first
      repeat (4) @(negedge clk);
      while (hostIrq !== 1'b1 && w < 20000) begin
         @(negedge clk);
         w++;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (hostIrq !== 1'b1 && n < 20000);
   endtask : measureGap

   task automatic countIrq(input int len, output int k);
      k = 0;
      repeat (20) @(negedge clk);
      repeat (len) begin
         @(negedge clk);
         if (hostIrq === 1'b1) k++;
      end
   endtask : countIrq

   // Clocks until the next update strobe, bounded
   task automatic waitStrobe(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (updateStrobe !== 1'b1 && n < 5000);
   endtask : waitStrobe

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic testRegisters;
      rtcdv_host_model_i.regWrite(`RTCDV_IDX_CTRL_B, 8'h80);
      rtcdv_host_model_i.regRead(`RTCDV_IDX_CTRL_B, rd);
      checkByte(rd, 8'h80);
      rtcdv_host_model_i.regWrite(`RTCDV_IDX_CTRL_B, 8'h00);
      rtcdv_host_model_i.regRead(`RTCDV_IDX_CTRL_A, rd);
      checkByte(rd, 8'h26);
      rtcdv_host_model_i.regWrite(`RTCDV_IDX_CTRL_A, 8'hA3);
      rtcdv_host_model_i.regRead(`RTCDV_IDX_CTRL_A, rd);
      checkByte(rd, 8'h23);
      rtcdv_host_model_i.portWrite(8'h72, `RTCDV_IDX_CTRL_B);
      rtcdv_host_model_i.portRead(`RTCDV_DATA_PORT, rd);
      checkByte(rd, 8'h23);
      rtcdv_host_model_i.regRead(8'h05, rd);
      checkByte(rd, 8'h00);
   endtask : testRegisters

   task automatic testDivider;
      logic [2:0] divs [3] = '{3'h0, 3'h1, 3'h2};
      int         facs [3] = '{128, 32, 1};
      for (int i = 0; i < 3; i++) begin
         setCtrl(divs[i], 4'h3);
         measureGap(gap);
         checkCount(gap, 4 * facs[i] * OSC_CLKS);
      end
   endtask : testDivider

   // Rates above 9 need a chain longer than the bench's
   task automatic testRates;
      int ticks;
      for (int r = 1; r < 10; r++) begin
         ticks = (r == 1) ? 128 : (r == 2) ? 256 : (1 << (r - 1));
         setCtrl(3'h2, 4'(r));
         measureGap(gap);
         checkCount(gap, ticks * OSC_CLKS);
      end
   endtask : testRates

   task automatic testSilence;
      setCtrl(3'h2, 4'h0);
      countIrq(1500, gap);
      checkCount(gap, 0);
      setCtrl(3'h6, 4'h3);
      countIrq(1500, gap);
      checkCount(gap, 0);
      setCtrl(3'h7, 4'h3);
      countIrq(1500, gap);
      checkCount(gap, 0);
      setCtrl(3'h4, 4'h3);
      countIrq(1500, gap);
      checkCount(gap, 0);
   endtask : testSilence

   task automatic testUpdate;
      int k;
      setCtrl(3'h2, 4'h0);
      waitStrobe(gap);
      waitStrobe(gap);
      checkCount(gap, (1 << CHAIN) * OSC_CLKS);
      rtcdv_host_model_i.regRead(`RTCDV_IDX_CTRL_A, rd);
      checkByte(rd, 8'hA0);
      repeat (600) @(negedge clk);
      rtcdv_host_model_i.regRead(`RTCDV_IDX_CTRL_A, rd);
      checkByte(rd, 8'h20);
      waitStrobe(gap);
      rtcdv_host_model_i.regWrite(`RTCDV_IDX_CTRL_B, 8'h80);
      rtcdv_host_model_i.regRead(`RTCDV_IDX_CTRL_A, rd);
      checkByte(rd, 8'h20);
      k = 0;
      repeat ((1 << CHAIN) * OSC_CLKS + 100) begin
         @(negedge clk);
         if (updateStrobe === 1'b1) k++;
      end
      checkCount(k, 0);
      rtcdv_host_model_i.regWrite(`RTCDV_IDX_CTRL_B, 8'h00);
   endtask : testUpdate

   task automatic testAlarm;
      @(negedge clk);
      alarmMatch = 1'b1;
      @(negedge clk);
      alarmMatch = 1'b0;
      checkByte({7'h00, hostIrq}, 8'h01);
      @(negedge clk);
      checkByte({7'h00, hostIrq}, 8'h00);
      setCtrl(3'h2, 4'h3);
      measureGap(gap);
      checkCount(gap, 4 * OSC_CLKS);
   endtask : testAlarm

   // ----------------------------------------
   // Main sequence and verdict
   // ----------------------------------------
   task automatic results;
      if (failures == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   initial begin
      rst_n = 1'b0;
      alarmMatch = 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      testRegisters();
      testDivider();
      testRates();
      testSilence();
      testAlarm();
      testUpdate();
      results();
   end
endmodule : test_rtc_divider_rate_control
